// ---- rtl/eii_pkg.sv ----
// shared constants for the external interrupt input and its cpu-side controller
package eii_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // device register map
  localparam logic [7:0]  EII_STSCTL_OFS   = 8'h1E;
  localparam logic [7:0]  EII_STSCTL_RST   = 8'h00;
  localparam int          EII_MODE_BIT     = 0;
  localparam int          EII_MASK_BIT     = 1;
  localparam int          EII_ACK_BIT      = 2;
  localparam int          EII_PEND_BIT     = 3;
  localparam logic        EII_PIN_IDLE     = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // vector location loaded when the request is taken
  localparam logic [15:0] EII_VECTOR_ADDR  = 16'hFFFA;

  ////////////////////////////////////////////////////////////////////////////////
  // controller registers on the axi4-lite side (byte addresses)
  localparam logic [7:0]  EII_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  EII_DEVWR_OFS    = 8'h04;
  localparam logic [7:0]  EII_DEVRD_OFS    = 8'h08;
  localparam logic [7:0]  EII_STATUS_OFS   = 8'h0C;
  localparam logic [7:0]  EII_INT_REQUEST_MASK_BIT_OFS    = 8'h10;
  localparam logic [7:0]  EII_LIVE_OFS     = 8'h14;
  localparam logic [7:0]  EII_VECTOR_OFS   = 8'h18;

  localparam int          EII_CTL_AUTO_BIT = 0;
  localparam int          EII_CTL_GMSK_BIT = 1;
  localparam int          EII_CTL_BRK_BIT  = 2;
  localparam int          EII_CTL_BREAK_CLEAR_ENABLE_BIT = 3;
  localparam int          EII_CTL_VF_BIT   = 4;

  localparam int          EII_EVT_REQ_BIT  = 0;
  localparam int          EII_EVT_VEC_BIT  = 1;

  localparam logic [1:0]  EII_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  EII_RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    EII_RD_IDLE = 2'b00,
    EII_RD_WAIT = 2'b01,
    EII_RD_RESP = 2'b11
  } eii_rd_state_t;

endpackage

// ---- rtl/eii_link_if.sv ----
// link between the interrupt input device and the cpu-side controller
`timescale 1ns/1ps
interface eii_link_if;
  // register port, driven by the cpu side
  logic [7:0] regAddr;
  logic       regWr;
  logic       regRd;
  logic [7:0] regWrData;
  // register answer, one cycle after regRd
  logic [7:0] regRdData;
  // cpu core and break control
  logic       vectorFetch;
  logic       breakState;
  logic       breakClearEnable;
  // towards the priority logic
  logic       intRequest;
  logic       pinLevel;

  modport dev (
    input  regAddr, regWr, regRd, regWrData, vectorFetch, breakState, breakClearEnable,
    output regRdData, intRequest, pinLevel
  );
  modport cpu (
    output regAddr, regWr, regRd, regWrData, vectorFetch, breakState, breakClearEnable,
    input  regRdData, intRequest, pinLevel
  );
endinterface // eii_link_if

// ---- rtl/eii_device.sv ----
// external interrupt input device: pin latch, sensitivity, mask and status register
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - pin edge or low level sets latch
// - vector fetch clears latch
// - write one to acknowledge clears latch
// - reset clears latch and sensitivity bit
// - edge mode: acknowledge clears immediately
// - level mode: needs acknowledge and pin high
// - level mode: pending while pin low
// - falling edge after acknowledge latches again
// - mask bit withholds request
// - cpu global mask blocks automatic take of request
// - taken request loads vector pair
// - pending flag ignores mask bit
// - break state blocks acknowledge unless enabled
// - break-time clear stays after break
// - acknowledge bit write-only, reads zero
// - pending flag bit three, upper zero
// - raw pin level for branch instructions
// - software masks in level-mode service routine
module eii_device (
  // system
  input  wire logic clk,
  input  wire logic reset_n,
  // cpu side
  eii_link_if.dev   link,
  // external pin, active low
  input  wire logic irqPin_n,
  // observation
  output logic      pendingOut,
  output logic      pinLevelOut
);
  import eii_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [1:0] pinSync;
    logic       pinPrev;
    logic       latch;
    logic       ackPend;
    logic       mode;
    logic       mask;
    logic [7:0] rdData;
    logic       intReq;
    logic       pinLevel;
  } eii_dev_state_t;

  localparam eii_dev_state_t EII_DEV_RST = '{
    pinSync:  {EII_PIN_IDLE, EII_PIN_IDLE},
    pinPrev:  EII_PIN_IDLE,
    latch:    1'b0,
    ackPend:  1'b0,
    mode:     EII_STSCTL_RST[EII_MODE_BIT],
    mask:     EII_STSCTL_RST[EII_MASK_BIT],
    rdData:   EII_STSCTL_RST,
    intReq:   1'b0,
    pinLevel: EII_PIN_IDLE
  };

  eii_dev_state_t state_q;
  eii_dev_state_t state_d;
  logic           pinHigh;
  logic           fallEdge;
  logic           levelSet;
  logic           regHit;
  logic           regWrHit;
  logic           swAck;
  logic           ackNow;

  ////////////////////////////////////////////////////////////////////////////////
  // readback layout; acknowledge position and upper nibble stay zero
  function automatic logic [7:0] stsCtlRead(input logic pend, input logic msk,
                                            input logic md);
    logic [7:0] r;
    r               = 8'h00;
    r[EII_PEND_BIT] = pend;
    r[EII_MASK_BIT] = msk;
    r[EII_MODE_BIT] = md;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_d         = state_q;

    // first stage feeds only the second
    state_d.pinSync = {state_q.pinSync[0], irqPin_n};
    pinHigh         = state_q.pinSync[1];
    state_d.pinPrev = pinHigh;
    fallEdge        = state_q.pinPrev & ~pinHigh;
    // level mode also catches a pin already low when the mode is set
    levelSet        = state_q.mode & ~pinHigh & ~state_q.latch;

    regHit          = (link.regAddr == EII_STSCTL_OFS);
    regWrHit        = link.regWr & regHit;
    swAck           = regWrHit & link.regWrData[EII_ACK_BIT];
    // break protects the latch from software only, fetches still clear it
    ackNow          = link.vectorFetch
                    | (swAck & (~link.breakState | link.breakClearEnable));

    if (regWrHit) begin
      state_d.mode = link.regWrData[EII_MODE_BIT];
      state_d.mask = link.regWrData[EII_MASK_BIT];
    end

    // a new edge wins over an acknowledge in the same cycle
    if (fallEdge || levelSet) begin
      state_d.latch   = 1'b1;
      state_d.ackPend = 1'b0;
    end else if (!state_q.mode) begin
      if (ackNow) begin
        state_d.latch = 1'b0;
      end
      state_d.ackPend = 1'b0;
    end else if ((ackNow || state_q.ackPend) && pinHigh) begin
      // cleared latch stays cleared once break ends
      state_d.latch   = 1'b0;
      state_d.ackPend = 1'b0;
    end else if (ackNow && state_q.latch) begin
      // acknowledge seen while pin still low, wait for release
      state_d.ackPend = 1'b1;
    end

    state_d.intReq   = state_d.latch & ~state_d.mask;
    state_d.pinLevel = pinHigh;

    if (link.regRd) begin
      if (regHit) begin
        state_d.rdData = stsCtlRead(state_q.latch, state_q.mask, state_q.mode);
      end else begin
        state_d.rdData = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= EII_DEV_RST;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.regRdData  = state_q.rdData;
  assign link.intRequest = state_q.intReq;
  assign link.pinLevel   = state_q.pinLevel;
  assign pendingOut      = state_q.latch;
  assign pinLevelOut     = state_q.pinLevel;

endmodule // eii_device

// ---- rtl/eii_cpu_ctrl.sv ----
// cpu-side controller: axi4-lite registers, vector fetch and break control
`timescale 1ns/1ps
module eii_cpu_ctrl (
  // system
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link to the device
  eii_link_if.cpu          link,
  // axi4-lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // interrupt
  output logic             irq
);
  import eii_pkg::*;

  typedef struct packed {
    logic          awHave;
    logic [7:0]    awAddr;
    logic          wHave;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    eii_rd_state_t rdState;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [3:0]    ctrl;
    logic          regWr;
    logic          regRd;
    logic [7:0]    regWrData;
    logic          vectorFetch;
    logic          reqPrev;
    logic [1:0]    sts;
    logic [1:0]    msk;
    logic [15:0]   lastVector;
    logic          irq;
  } eii_ctl_state_t;

  eii_ctl_state_t state_q;
  eii_ctl_state_t state_d;
  logic           doWrite;
  logic           manualFetch;
  logic [1:0]     stsClr;
  logic [1:0]     evt;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_d       = state_q;
    state_d.regWr = 1'b0;
    state_d.regRd = 1'b0;
    manualFetch   = 1'b0;
    stsClr        = 2'b00;

    // write channels, taken in either order
    if (awvalid && state_q.awready) begin
      state_d.awHave = 1'b1;
      state_d.awAddr = awaddr;
    end
    if (wvalid && state_q.wready) begin
      state_d.wHave = 1'b1;
      state_d.wData = wdata;
      state_d.wStrb = wstrb;
    end
    if (state_q.bvalid && bready) begin
      state_d.bvalid = 1'b0;
    end
    doWrite = state_q.awHave & state_q.wHave & ~state_q.bvalid;
    if (doWrite) begin
      state_d.awHave = 1'b0;
      state_d.wHave  = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp  = EII_RESP_OKAY;
      case (state_q.awAddr)
        EII_CTRL_OFS: begin
          if (state_q.wStrb[0]) begin
            state_d.ctrl = state_q.wData[3:0];
            manualFetch  = state_q.wData[EII_CTL_VF_BIT];
          end
        end
        EII_DEVWR_OFS: begin
          if (state_q.wStrb[0]) begin
            state_d.regWr     = 1'b1;
            state_d.regWrData = state_q.wData[7:0];
          end
        end
        EII_STATUS_OFS: begin
          if (state_q.wStrb[0]) begin
            stsClr = state_q.wData[1:0];
          end
        end
        EII_INT_REQUEST_MASK_BIT_OFS: begin
          if (state_q.wStrb[0]) begin
            state_d.msk = state_q.wData[1:0];
          end
        end
        default: begin
          state_d.bresp = EII_RESP_SLVERR;
        end
      endcase
    end
    state_d.awready = ~state_d.awHave & ~state_d.bvalid;
    state_d.wready  = ~state_d.wHave & ~state_d.bvalid;

    // read channel; device register answers one cycle after regRd
    case (state_q.rdState)
      EII_RD_IDLE: begin
        if (arvalid && state_q.arready) begin
          state_d.rresp   = EII_RESP_OKAY;
          state_d.rdata   = 32'h0000_0000;
          state_d.rdState = EII_RD_RESP;
          state_d.rvalid  = 1'b1;
          case (araddr)
            EII_CTRL_OFS:   state_d.rdata[3:0]  = state_q.ctrl;
            EII_DEVWR_OFS:  state_d.rdata       = 32'h0000_0000;
            EII_DEVRD_OFS: begin
              state_d.regRd   = 1'b1;
              state_d.rvalid  = 1'b0;
              state_d.rdState = EII_RD_WAIT;
            end
            EII_STATUS_OFS: state_d.rdata[1:0]  = state_q.sts;
            EII_INT_REQUEST_MASK_BIT_OFS:  state_d.rdata[1:0]  = state_q.msk;
            // branch-on-pin views of the raw level in bits 2:1, request in bit 0
            EII_LIVE_OFS:   state_d.rdata[2:0]  = {~link.pinLevel, link.pinLevel,
                                                   link.intRequest};
            EII_VECTOR_OFS: state_d.rdata[15:0] = state_q.lastVector;
            default:        state_d.rresp       = EII_RESP_SLVERR;
          endcase
        end
      end
      EII_RD_WAIT: begin
        // device answer registers on the edge that ends the regRd pulse
        if (!state_q.regRd) begin
          state_d.rdata   = {24'h00_0000, link.regRdData};
          state_d.rvalid  = 1'b1;
          state_d.rdState = EII_RD_RESP;
        end
      end
      EII_RD_RESP: begin
        if (rready) begin
          state_d.rvalid  = 1'b0;
          state_d.rdState = EII_RD_IDLE;
        end
      end
      default: begin
        state_d.rvalid  = 1'b0;
        state_d.rdState = EII_RD_IDLE;
      end
    endcase
    state_d.arready = (state_d.rdState == EII_RD_IDLE) & ~(arvalid & state_q.arready);

    // auto take only outside the global mask, manual fetch ignores it; skip the cycle the device still shows it
    state_d.vectorFetch = manualFetch
                        | (state_q.ctrl[EII_CTL_AUTO_BIT] & ~state_q.ctrl[EII_CTL_GMSK_BIT]
                           & link.intRequest & ~state_q.vectorFetch);
    if (state_d.vectorFetch) begin
      state_d.lastVector = EII_VECTOR_ADDR;
    end

    // sticky events, a new event wins over its clear
    state_d.reqPrev = link.intRequest;
    evt                  = 2'b00;
    evt[EII_EVT_REQ_BIT] = link.intRequest & ~state_q.reqPrev;
    evt[EII_EVT_VEC_BIT] = state_d.vectorFetch;
    state_d.sts          = (state_q.sts & ~stsClr) | evt;
    state_d.irq          = |(state_d.sts & state_d.msk);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign awready               = state_q.awready;
  assign wready                = state_q.wready;
  assign bvalid                = state_q.bvalid;
  assign bresp                 = state_q.bresp;
  assign arready               = state_q.arready;
  assign rvalid                = state_q.rvalid;
  assign rdata                 = state_q.rdata;
  assign rresp                 = state_q.rresp;
  assign irq                   = state_q.irq;
  assign link.regAddr          = EII_STSCTL_OFS;
  assign link.regWr            = state_q.regWr;
  assign link.regRd            = state_q.regRd;
  assign link.regWrData        = state_q.regWrData;
  assign link.vectorFetch      = state_q.vectorFetch;
  assign link.breakState       = state_q.ctrl[EII_CTL_BRK_BIT];
  assign link.breakClearEnable = state_q.ctrl[EII_CTL_BREAK_CLEAR_ENABLE_BIT];

endmodule // eii_cpu_ctrl

// ---- tb/eii_link_checker.sv ----
// assertions on the link between the interrupt input and its cpu-side controller
`timescale 1ns/1ps
module eii_link_checker (
  // system
  input wire logic       clk,
  input wire logic       reset_n,
  // link signals
  input wire logic [7:0] regAddr,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       vectorFetch,
  input wire logic       breakState,
  input wire logic       breakClearEnable,
  input wire logic       intRequest,
  input wire logic       pinLevel
);
  import eii_pkg::*;
  typedef struct packed {
    logic mode;
    logic mask;
  } eii_shadow_t;
  eii_shadow_t shadow_q;
  eii_shadow_t shadow_d;
  logic        devWr;
  assign devWr = regWr && (regAddr == EII_STSCTL_OFS);
  // shadow copy of mode and mask as written over the link
  always_comb begin
    shadow_d = shadow_q;
    if (devWr) begin
      shadow_d.mode = regWrData[EII_MODE_BIT];
      shadow_d.mask = regWrData[EII_MASK_BIT];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_q <= '0;
    end else begin
      shadow_q <= shadow_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pin high on both sides of the ack, so no fresh edge can win
  sequence sAckPinHigh;
    (vectorFetch || (devWr && regWrData[EII_ACK_BIT] && (!breakState || breakClearEnable)))
      && pinLevel ##1 pinLevel;
  endsequence
  sequence sLowHeld;
    (shadow_q.mode && !shadow_q.mask && !regWr && !pinLevel) [*4];
  endsequence
  AST_ACK_CLEARS: assert property (sAckPinHigh |-> !intRequest)
    else $error("acknowledge left request set");
  AST_BRK_HOLDS: assert property (devWr && regWrData[EII_ACK_BIT] && breakState
    && !breakClearEnable && !vectorFetch && !regWrData[EII_MASK_BIT] && intRequest
    |=> intRequest) else $error("ack in protected break cleared latch");
  AST_MASK_WITHHOLDS: assert property (devWr && regWrData[EII_MASK_BIT] |=> !intRequest)
    else $error("masked request still presented");
  AST_LEVEL_PENDS: assert property (sLowHeld |-> intRequest)
    else $error("low pin in level mode not pending");
  AST_FALL_LATCHES: assert property ($fell(pinLevel) && !shadow_q.mask && !regWr
    |-> ##[0:3] intRequest) else $error("falling edge not latched");
  AST_VF_PULSE: assert property (vectorFetch |=> !vectorFetch)
    else $error("vector fetch longer than one cycle");
  AST_RD_ZEROS: assert property (regRd |=> regRdData[7:4] == 4'h0 && !regRdData[2])
    else $error("unimplemented or ack bit read nonzero");
  AST_RD_CTRL: assert property (regRd && !regWr
    |=> regRdData[1:0] == {shadow_q.mask, shadow_q.mode}) else $error("mode or mask readback");
endmodule // eii_link_checker

// ---- tb/external_interrupt_input_tb_top.sv ----
// bench driving the controller over axi4-lite and the device pin
`timescale 1ns/1ps
module external_interrupt_input_tb_top;
  import eii_pkg::*;
  logic        clk, reset_n, irqPin_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rnd;
  wire         awready, wready, bvalid, arready, rvalid, irq, pendingOut, pinLevelOut;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [33:0] expQ[$];
  int          badCount, samplesChecked;

  eii_link_if eii_link_if_i ();
  eii_device eii_device_i (.clk(clk), .reset_n(reset_n), .link(eii_link_if_i),
    .irqPin_n(irqPin_n), .pendingOut(pendingOut), .pinLevelOut(pinLevelOut));
  eii_cpu_ctrl eii_cpu_ctrl_i (.clk(clk), .reset_n(reset_n), .link(eii_link_if_i),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .irq(irq));
  eii_link_checker eii_link_checker_i (.clk(clk), .reset_n(reset_n),
    .regAddr(eii_link_if_i.regAddr), .regWr(eii_link_if_i.regWr), .regRd(eii_link_if_i.regRd),
    .regWrData(eii_link_if_i.regWrData), .regRdData(eii_link_if_i.regRdData),
    .vectorFetch(eii_link_if_i.vectorFetch), .breakState(eii_link_if_i.breakState),
    .breakClearEnable(eii_link_if_i.breakClearEnable),
    .intRequest(eii_link_if_i.intRequest), .pinLevel(eii_link_if_i.pinLevel));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    samplesChecked++;
    if (seen !== want) begin
      badCount++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // upper data bits are random; only the low byte carries meaning
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = EII_RESP_OKAY);
    rnd = lfsr(rnd);
    expQ.push_back({r, 32'h0});
    awaddr  <= a;
    wdata   <= {rnd[31:8], d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = EII_RESP_OKAY);
    expQ.push_back({r, e});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) rready <= 1'b0;
    end while (arvalid || rready);
  endtask

  // margin over the two-stage synchroniser and edge compare
  task automatic pin(input logic v);
    irqPin_n <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (bvalid && bready) check({bresp, 32'h0}, expQ.pop_front());
    if (rvalid && rready) check({rresp, rdata}, expQ.pop_front());
  end

  initial begin
    #200000;
    badCount++;
    wrapUp();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, irqPin_n, awvalid, wvalid, bready, arvalid, rready} = 7'h20;
    {awaddr, araddr, wdata} = '0;
    rnd = 32'h517542AC;
    badCount = 0;
    samplesChecked = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(EII_DEVRD_OFS, 32'h0);
    rd(EII_CTRL_OFS, 32'h0);
    rd(EII_LIVE_OFS, 32'h2);
    rd(EII_VECTOR_OFS, 32'h0);
    rd(8'h1C, 32'h0, EII_RESP_SLVERR);
    wr(8'h1C, 8'hFF, EII_RESP_SLVERR);
    check({33'h0, pinLevelOut}, 34'h1);
    $display("test reset done");
    wr(EII_INT_REQUEST_MASK_BIT_OFS, 8'h01);
    pin(1'b0);
    rd(EII_DEVRD_OFS, 32'h8);
    rd(EII_LIVE_OFS, 32'h5);
    check({33'h0, irq}, 34'h1);
    wr(EII_DEVWR_OFS, 8'h04);
    rd(EII_DEVRD_OFS, 32'h0);
    pin(1'b1);
    pin(1'b0);
    rd(EII_DEVRD_OFS, 32'h8);
    wr(EII_STATUS_OFS, 8'h01);
    check({33'h0, irq}, 34'h0);
    pin(1'b1);
    $display("test edge done");
    wr(EII_DEVWR_OFS, 8'h02);
    rd(EII_DEVRD_OFS, 32'hA);
    rd(EII_LIVE_OFS, 32'h2);
    wr(EII_DEVWR_OFS, 8'h00);
    rd(EII_STATUS_OFS, 32'h1);
    check({33'h0, irq}, 34'h1);
    wr(EII_DEVWR_OFS, 8'h04);
    $display("test mask done");
    wr(EII_DEVWR_OFS, 8'h01);
    pin(1'b0);
    rd(EII_DEVRD_OFS, 32'h9);
    wr(EII_DEVWR_OFS, 8'h05);
    rd(EII_DEVRD_OFS, 32'h9);
    pin(1'b1);
    rd(EII_DEVRD_OFS, 32'h1);
    pin(1'b0);
    pin(1'b1);
    rd(EII_DEVRD_OFS, 32'h9);
    wr(EII_DEVWR_OFS, 8'h05);
    rd(EII_DEVRD_OFS, 32'h1);
    $display("test level done");
    wr(EII_DEVWR_OFS, 8'h00);
    pin(1'b0);
    pin(1'b1);
    wr(EII_CTRL_OFS, 8'h04);
    wr(EII_DEVWR_OFS, 8'h04);
    rd(EII_DEVRD_OFS, 32'h8);
    wr(EII_CTRL_OFS, 8'h0C);
    rd(EII_CTRL_OFS, 32'hC);
    wr(EII_DEVWR_OFS, 8'h04);
    rd(EII_DEVRD_OFS, 32'h0);
    wr(EII_CTRL_OFS, 8'h00);
    rd(EII_DEVRD_OFS, 32'h0);
    $display("test break done");
    pin(1'b0);
    pin(1'b1);
    wr(EII_CTRL_OFS, 8'h10);
    rd(EII_DEVRD_OFS, 32'h0);
    rd(EII_VECTOR_OFS, 32'hFFFA);
    wr(EII_CTRL_OFS, 8'h03);
    pin(1'b0);
    pin(1'b1);
    rd(EII_DEVRD_OFS, 32'h8);
    wr(EII_CTRL_OFS, 8'h01);
    rd(EII_DEVRD_OFS, 32'h0);
    wr(EII_CTRL_OFS, 8'h00);
    $display("test fetch done");
    wr(EII_DEVWR_OFS, 8'h01);
    pin(1'b0);
    check({33'h0, pendingOut}, 34'h1);
    reset_n <= 1'b0;
    @(posedge clk);
    check({33'h0, pendingOut}, 34'h0);
    irqPin_n <= 1'b1;
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(EII_DEVRD_OFS, 32'h0);
    $display("test midreset done");
    wrapUp();
  end
endmodule // external_interrupt_input_tb_top
